// >>> hdl/clk_gate_params.svh
// Constants of the sleep-mode clock gating controller
`ifndef CLK_GATE_PARAMS_SVH
`define CLK_GATE_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define RUN_CFG_OFFSET  12'h060
`define RCG_OFFSET      12'h100
`define SCG_OFFSET      12'h110
`define DCG_OFFSET      12'h120
`define IRQ_STAT_OFFSET 12'h130
`define IRQ_CLR_OFFSET  12'h134
`define IRQ_EN_OFFSET   12'h138

// ------------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------------
`define GATE_RESET      32'h00000040
`define GATE_RW_MASK    32'h00110308
`define RUN_CFG_RESET   32'h00000000
`define WDOG_BIT        3
`define ADC_BIT         16
`define PWM_BIT         20
`define RATE_LSB        8
`define RATE_MSB        9
`define AUTO_GATE_BIT   0
`define RATE_125K       2'h0
`define RATE_250K       2'h1
`define RATE_500K       2'h2
`define RATE_MAX        2'h2
`define EVT_MASK        32'h00000007

`endif

// >>> hdl/clk_gate_pkg.sv
// Types and field helpers of the sleep-mode clock gating controller
package clk_gate_pkg;
`include "clk_gate_params.svh"

    typedef struct packed {
        logic       pwm;
        logic       adc;
        logic [1:0] rate;
        logic       wdog;
    } gate_cfg_t;

    // Order pwm, adc, wdog: bit 0 is the watchdog
    typedef struct packed {
        logic pwm;
        logic adc;
        logic wdog;
    } unit_vec_t;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_DEEP  = 3'b100
    } pwr_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_RDWAIT = 2'b10
    } bus_state_t;

    function automatic gate_cfg_t cfg_from_word(input logic [31:0] w);
        gate_cfg_t c;
        c.pwm  = w[`PWM_BIT];
        c.adc  = w[`ADC_BIT];
        c.rate = w[`RATE_MSB:`RATE_LSB];
        c.wdog = w[`WDOG_BIT];
        return c;
    endfunction

    function automatic logic [31:0] cfg_to_word(input gate_cfg_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[`PWM_BIT] = c.pwm;
        w[`ADC_BIT] = c.adc;
        w[`RATE_MSB:`RATE_LSB] = c.rate;
        w[`WDOG_BIT] = c.wdog;
        return w;
    endfunction
endpackage

// >>> hdl/level_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // level_sync

// >>> hdl/clk_gate_ctrl.sv
// Sleep-mode clock gating controller with AHB-Lite register slave
`timescale 1ns/1ps
module clk_gate_ctrl
    import clk_gate_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        SRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SLEEP_REQ,
    input  wire logic        DEEP_SLEEP_REQ,
    input  wire unit_vec_t   UNIT_ACCESS,
    output unit_vec_t        UNIT_FAULT,
    output unit_vec_t        UNIT_CLK_EN,
    output logic      [1:0]  ADC_RATE,
    output logic             IRQ
);
    // ------------------------------------------------------------------
    // Power mode requests from the pins
    // ------------------------------------------------------------------
    logic [1:0]  mode_req;
    logic        sleep_s;
    logic        deep_s;

    level_sync #(.W(2)) u_sync (
        .clk (MCLK),
        .rst (SRST),
        .d   ({DEEP_SLEEP_REQ, SLEEP_REQ}),
        .q   (mode_req)
    );
    assign sleep_s = mode_req[0];
    assign deep_s  = mode_req[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bus_state_t  state_r, state_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic        ready_r, ready_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    gate_cfg_t   rcg_r, rcg_nxt;
    gate_cfg_t   scg_r, scg_nxt;
    gate_cfg_t   dcg_r, dcg_nxt;
    logic        auto_gate_r, auto_gate_nxt;
    unit_vec_t   stat_r, stat_nxt;
    unit_vec_t   en_r, en_nxt;
    pwr_mode_t   mode_r, mode_nxt;
    unit_vec_t   clk_en_r, clk_en_nxt;
    logic [1:0]  rate_r, rate_nxt;
    unit_vec_t   fault_r, fault_nxt;
    logic        irq_r, irq_nxt;
    logic        acc;
    logic [31:0] rd_word;
    gate_cfg_t   act_cfg;
    unit_vec_t   clr_vec;

    assign acc = HSEL && HTRANS[1] && HREADY;

    // ------------------------------------------------------------------
    // Bus slave: writes commit in the data phase, reads take one wait
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        unique case (addr_r)
            `RUN_CFG_OFFSET:  rd_word[`AUTO_GATE_BIT] = auto_gate_r;
            `RCG_OFFSET:      rd_word = cfg_to_word(rcg_r);
            `SCG_OFFSET:      rd_word = cfg_to_word(scg_r);
            `DCG_OFFSET:      rd_word = cfg_to_word(dcg_r);
            `IRQ_STAT_OFFSET: rd_word = {29'h0, stat_r};
            `IRQ_EN_OFFSET:   rd_word = {29'h0, en_r};
            default:          rd_word = 32'h00000000;
        endcase
    end

    always_comb begin
        state_nxt   = state_r;
        wr_pend_nxt = acc && HWRITE;
        addr_nxt    = acc ? HADDR[11:0] : addr_r;
        ready_nxt   = 1'b1;
        hrdata_nxt  = hrdata_r;
        unique case (state_r)
            BUS_IDLE: begin
                // Wait state lets a write just ahead land before the read
                if (acc && !HWRITE) begin
                    state_nxt = BUS_RDWAIT;
                    ready_nxt = 1'b0;
                end
            end
            BUS_RDWAIT: begin
                hrdata_nxt = rd_word;
                state_nxt  = BUS_IDLE;
            end
            default: begin
                state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_r   <= BUS_IDLE;
            wr_pend_r <= 1'b0;
            addr_r    <= 12'h000;
            ready_r   <= 1'b1;
            hrdata_r  <= 32'h00000000;
        end else begin
            state_r   <= state_nxt;
            wr_pend_r <= wr_pend_nxt;
            addr_r    <= addr_nxt;
            ready_r   <= ready_nxt;
            hrdata_r  <= hrdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and interrupt registers
    // ------------------------------------------------------------------
    always_comb begin
        rcg_nxt = rcg_r;
        scg_nxt = scg_r;
        dcg_nxt = dcg_r;
        auto_gate_nxt = auto_gate_r;
        en_nxt  = en_r;
        clr_vec = unit_vec_t'(3'h0);
        if (wr_pend_r) begin
            // Reserved bits are dropped by the field unpacking
            unique case (addr_r)
                `RUN_CFG_OFFSET: auto_gate_nxt = HWDATA[`AUTO_GATE_BIT];
                `RCG_OFFSET:    rcg_nxt = cfg_from_word(HWDATA);
                `SCG_OFFSET:    scg_nxt = cfg_from_word(HWDATA);
                `DCG_OFFSET:    dcg_nxt = cfg_from_word(HWDATA);
                `IRQ_EN_OFFSET: en_nxt  = unit_vec_t'(HWDATA[2:0]);
                `IRQ_CLR_OFFSET: clr_vec = unit_vec_t'(HWDATA[2:0]);
                default: ;
            endcase
        end
        // New fault beats a clear in the same cycle
        stat_nxt = unit_vec_t'((stat_r & ~clr_vec) | fault_nxt);
        irq_nxt  = |(stat_r & en_r);
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rcg_r  <= cfg_from_word(`GATE_RESET);
            scg_r  <= cfg_from_word(`GATE_RESET);
            dcg_r  <= cfg_from_word(`GATE_RESET);
            auto_gate_r <= 1'(`RUN_CFG_RESET);
            stat_r <= unit_vec_t'(3'h0);
            en_r   <= unit_vec_t'(3'h0);
            irq_r  <= 1'b0;
        end else begin
            rcg_r  <= rcg_nxt;
            scg_r  <= scg_nxt;
            dcg_r  <= dcg_nxt;
            auto_gate_r <= auto_gate_nxt;
            stat_r <= stat_nxt;
            en_r   <= en_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Mode selection, clock enables, rate and faults
    // ------------------------------------------------------------------
    always_comb begin
        if (auto_gate_r && deep_s) begin
            mode_nxt = MODE_DEEP;
        end else if (auto_gate_r && sleep_s) begin
            mode_nxt = MODE_SLEEP;
        end else begin
            mode_nxt = MODE_RUN;
        end
        unique case (mode_r)
            MODE_SLEEP: act_cfg = scg_r;
            MODE_DEEP:  act_cfg = dcg_r;
            default:    act_cfg = rcg_r;
        endcase
        clk_en_nxt = '{pwm: act_cfg.pwm, adc: act_cfg.adc,
                       wdog: act_cfg.wdog};
        // Above the top code the ADC still gets its fastest rate
        rate_nxt = (act_cfg.rate > `RATE_MAX) ? `RATE_MAX
                                              : act_cfg.rate;
        fault_nxt = unit_vec_t'(UNIT_ACCESS & ~clk_en_r);
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            mode_r   <= MODE_RUN;
            clk_en_r <= unit_vec_t'(3'h0);
            rate_r   <= `RATE_125K;
            fault_r  <= unit_vec_t'(3'h0);
        end else begin
            mode_r   <= mode_nxt;
            clk_en_r <= clk_en_nxt;
            rate_r   <= rate_nxt;
            fault_r  <= fault_nxt;
        end
    end

    assign HRDATA      = hrdata_r;
    assign HREADYOUT   = ready_r;
    assign HRESP       = 1'b0;
    assign UNIT_FAULT  = fault_r;
    assign UNIT_CLK_EN = clk_en_r;
    assign ADC_RATE    = rate_r;
    assign IRQ         = irq_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    unit_vec_t   fault_cause;
    unit_vec_t   scg_units;
    logic [1:0]  act_rate;
    logic        wr_scg;
    logic [31:0] wmasked;
    logic        rd_gate;
    assign fault_cause = unit_vec_t'(UNIT_ACCESS & ~UNIT_CLK_EN);
    assign scg_units   = '{pwm: scg_r.pwm, adc: scg_r.adc, wdog: scg_r.wdog};
    assign act_rate    = act_cfg.rate;
    assign wr_scg      = wr_pend_r && (addr_r == `SCG_OFFSET);
    assign wmasked     = HWDATA & `GATE_RW_MASK;
    assign rd_gate     = (state_r == BUS_RDWAIT) &&
                         (addr_r inside {`RCG_OFFSET, `SCG_OFFSET,
                                         `DCG_OFFSET});

    property p_fault_gated;
        1'b1 |=> (UNIT_FAULT == $past(fault_cause));
    endproperty
    a_fault_gated: assert property (p_fault_gated)
        else $error("fault does not follow access to gated unit");

    property p_clocked_no_fault;
        (UNIT_ACCESS & ~UNIT_CLK_EN) == 3'h0 |=> UNIT_FAULT == 3'h0;
    endproperty
    a_clocked_no_fault: assert property (p_clocked_no_fault)
        else $error("fault on a clocked unit");

    property p_reset_off;
        $fell(SRST) |-> (UNIT_CLK_EN == 3'h0) && (ADC_RATE == 2'h0);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("units not unclocked after reset");

    property p_run_without_auto;
        !auto_gate_r |=> (mode_r == MODE_RUN);
    endproperty
    a_run_without_auto: assert property (p_run_without_auto)
        else $error("sleep settings used without auto gating");

    property p_sleep_uses_scg;
        (mode_r == MODE_SLEEP) |=> (UNIT_CLK_EN == $past(scg_units));
    endproperty
    a_sleep_uses_scg: assert property (p_sleep_uses_scg)
        else $error("sleep mode does not follow sleep register");

    property p_rate_pass;
        (act_rate <= 2'h2) |=> (ADC_RATE == $past(act_rate));
    endproperty
    a_rate_pass: assert property (p_rate_pass)
        else $error("sample rate not taken from field");

    property p_rate_clamp;
        (act_rate == 2'h3) |=> (ADC_RATE == 2'h2);
    endproperty
    a_rate_clamp: assert property (p_rate_clamp)
        else $error("unencoded rate not clamped to highest");

    property p_write_scg;
        wr_scg |=> (cfg_to_word(scg_r) == $past(wmasked));
    endproperty
    a_write_scg: assert property (p_write_scg)
        else $error("sleep register write lost or reserved bit kept");

    property p_reserved_zero;
        rd_gate |=> ((HRDATA & ~`GATE_RW_MASK) == 32'h00000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit reads nonzero");

    property p_read_wait;
        (acc && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read answer not after one wait state");

    c_sleep_mode: cover property (mode_r == MODE_SLEEP);
    c_fault: cover property (UNIT_FAULT != 3'h0);
    c_clamp: cover property (act_rate == 2'h3 && mode_r == MODE_SLEEP);
    c_irq: cover property ($rose(IRQ));
endmodule // clk_gate_ctrl

// >>> tb/sleep_mode_clock_gating_tb.sv
// Self-checking testbench of the sleep-mode clock gating controller
`timescale 1ns/1ps
`include "clk_gate_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("Error at %0t: got %0h expected %0h", \
    $time, (g), (e)); end end
module sleep_mode_clock_gating_tb
    import clk_gate_pkg::*;
;
    logic        mclk = 1'h0;
    logic        srst = 1'h1;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sleep_req = 1'h0;
    logic        deep_req = 1'h0;
    unit_vec_t   ua = 3'h0;
    unit_vec_t   fault;
    unit_vec_t   clk_en;
    logic [1:0]  adc_rate;
    logic        irq;
    logic [31:0] rd_data;
    int          err_total = 0;
    int          num_checks = 0;

    always #12.5 mclk = ~mclk;

    clk_gate_ctrl clk_gate_ctrl_inst (
        .MCLK(mclk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .SLEEP_REQ(sleep_req),
        .DEEP_SLEEP_REQ(deep_req), .UNIT_ACCESS(ua),
        .UNIT_FAULT(fault), .UNIT_CLK_EN(clk_en),
        .ADC_RATE(adc_rate), .IRQ(irq)
    );

    // ------------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------------
    // Address phase held until hready, then data phase until hready
    task automatic bus_xfer(input logic wr, input logic [11:0] a,
                            input logic [31:0] d);
        int waits;
        waits = 0;
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h00000, a};
        do @(posedge mclk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        // Reads take exactly one wait state, writes none
        do begin
            @(posedge mclk);
            waits += (hreadyout !== 1'h1);
        end while (hreadyout !== 1'h1);
        rd_data = hrdata;
        `CHK(waits, wr ? 0 : 1)
        `CHK(hresp, 1'h0)
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        bus_xfer(1'h1, a, d);
    endtask

    task automatic bus_rd(input logic [11:0] a);
        bus_xfer(1'h0, a, 32'h0);
    endtask

    // Outputs land two edges after a write; sampled one edge later
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [11:0] offs [4];
        offs = '{`RUN_CFG_OFFSET, `RCG_OFFSET, `SCG_OFFSET, `DCG_OFFSET};
        `CHK(clk_en, 3'h0)
        `CHK(adc_rate, 2'h0)
        `CHK(irq, 1'h0)
        foreach (offs[i]) begin
            bus_rd(offs[i]);
            `CHK(rd_data, 32'h00000000)
        end
    endtask

    task automatic t_reserved;
        bus_wr(`SCG_OFFSET, 32'hFFFFFFFF);
        bus_rd(`SCG_OFFSET);
        `CHK(rd_data, 32'h00110308)
        bus_wr(`SCG_OFFSET, 32'h00000000);
        bus_rd(`SCG_OFFSET);
        `CHK(rd_data, 32'h00000000)
        bus_wr(12'h200, 32'hFFFFFFFF);
        bus_rd(12'h200);
        `CHK(rd_data, 32'h00000000)
        bus_wr(`IRQ_STAT_OFFSET, 32'h00000007);
        bus_rd(`IRQ_STAT_OFFSET);
        `CHK(rd_data, 32'h00000000)
    endtask

    task automatic t_mode;
        sleep_req <= 1'h1;
        bus_wr(`SCG_OFFSET, 32'h00110308);
        settle(6);
        `CHK(clk_en, 3'h0)
        bus_wr(`RUN_CFG_OFFSET, 32'h00000001);
        settle(3);
        `CHK(clk_en, 3'h7)
        `CHK(adc_rate, 2'h2)
        bus_wr(`DCG_OFFSET, 32'h00000008);
        deep_req <= 1'h1;
        settle(6);
        `CHK(clk_en, 3'h1)
        deep_req <= 1'h0;
        bus_wr(`RUN_CFG_OFFSET, 32'h00000000);
        bus_wr(`RCG_OFFSET, 32'h00010000);
        settle(6);
        `CHK(clk_en, 3'h2)
    endtask

    task automatic t_fields;
        logic [31:0] wd [3];
        logic [2:0]  ex [3];
        wd = '{32'h00000008, 32'h00010000, 32'h00100000};
        ex = '{3'h1, 3'h2, 3'h4};
        bus_wr(`RUN_CFG_OFFSET, 32'h00000001);
        for (int i = 0; i < 3; i++) begin
            bus_wr(`SCG_OFFSET, {22'h0, i[1:0], 8'h00});
            settle(3);
            `CHK(adc_rate, i[1:0])
            bus_wr(`SCG_OFFSET, wd[i]);
            settle(3);
            `CHK(clk_en, ex[i])
        end
    endtask

    // Units gated off: each access must fault and latch status
    task automatic t_fault;
        unit_vec_t v;
        bus_wr(`SCG_OFFSET, 32'h00000000);
        bus_wr(`IRQ_EN_OFFSET, 32'h00000007);
        settle(3);
        for (int i = 0; i < 3; i++) begin
            v = unit_vec_t'(3'h1 << i);
            ua <= v;
            @(posedge mclk);
            ua <= 3'h0;
            @(posedge mclk);
            `CHK(fault, v)
            @(posedge mclk);
            `CHK(fault, 3'h0)
            `CHK(irq, 1'h1)
            bus_rd(`IRQ_STAT_OFFSET);
            `CHK(rd_data, {29'h0, v})
            bus_wr(`IRQ_CLR_OFFSET, {29'h0, v});
            bus_rd(`IRQ_STAT_OFFSET);
            `CHK(rd_data, 32'h00000000)
            `CHK(irq, 1'h0)
        end
        bus_wr(`IRQ_EN_OFFSET, 32'h00000000);
        ua <= 3'h4;
        @(posedge mclk);
        ua <= 3'h0;
        settle(3);
        `CHK(irq, 1'h0)
        bus_rd(`IRQ_STAT_OFFSET);
        `CHK(rd_data, 32'h00000004)
        // Fault held across the clear: the set must win
        ua <= 3'h4;
        bus_wr(`IRQ_CLR_OFFSET, 32'h00000004);
        ua <= 3'h0;
        bus_rd(`IRQ_STAT_OFFSET);
        `CHK(rd_data, 32'h00000004)
        bus_wr(`IRQ_CLR_OFFSET, 32'h00000007);
        bus_wr(`SCG_OFFSET, 32'h00110308);
        settle(3);
        ua <= 3'h7;
        @(posedge mclk);
        ua <= 3'h0;
        @(posedge mclk);
        `CHK(fault, 3'h0)
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic final_report;
        $display("Checks: %0d, mismatches: %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
        t_reset();
        t_reserved();
        t_mode();
        t_fields();
        t_fault();
        // Second reset with the run and gate registers dirty
        srst <= 1'h1;
        repeat (4) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
        t_reset();
        final_report();
    end

    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule // sleep_mode_clock_gating_tb
